// ### src/mlhs_pkg.sv
// Constants and types shared by the modem link handshake sequencer
package mlhs_pkg;

  // ****************************************
  // Data path
  // ****************************************
  localparam int unsigned BYTE_W      = 8;
  localparam int unsigned BIT_CNT_W   = 3;
  localparam logic [7:0]  EOT_CHAR    = 8'h04;
  localparam logic [2:0]  LAST_BIT    = 3'h7;
  localparam logic [3:0]  BITS_IN_BYTE = 4'h8;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_MHZ          = 100;
  localparam int unsigned CTS_TIMEOUT_US   = 1000;
  localparam int unsigned CTS_TIMEOUT_CYC  = CTS_TIMEOUT_US * CLK_MHZ;

  // ****************************************
  // Sequencer states
  // ****************************************
  typedef enum logic [5:0] {
    ST_OFF      = 6'h01,
    ST_IDLE     = 6'h02,
    ST_WAIT_CTS = 6'h04,
    ST_SEND     = 6'h08,
    ST_EOT      = 6'h10,
    ST_DROP     = 6'h20
  } mlhs_state_t;

endpackage

// ### src/mlhs_buf.sv
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/100ps
module mlhs_buf
  import mlhs_pkg::*;
#(
  parameter int unsigned W = BYTE_W
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         nrst,
  // Fill side
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  // Drain side
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);

  // ****************************************
  // Head and skid entries
  // ****************************************
  logic         out_valid_q;
  logic [W-1:0] out_data_q;
  logic         skid_valid_q;
  logic [W-1:0] skid_data_q;

  wire head_free = out_ready || !out_valid_q;
  wire push      = in_valid && !skid_valid_q;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      out_valid_q  <= 1'b0;
      out_data_q   <= '0;
      skid_valid_q <= 1'b0;
      skid_data_q  <= '0;
    end else if (head_free) begin
      // Skid drains first so word order is kept
      out_valid_q  <= skid_valid_q || push;
      out_data_q   <= skid_valid_q ? skid_data_q : in_data;
      skid_valid_q <= skid_valid_q && push;
      skid_data_q  <= in_data;
    end else if (push) begin
      skid_valid_q <= 1'b1;
      skid_data_q  <= in_data;
    end
  end

  assign in_ready  = !skid_valid_q;
  assign out_valid = out_valid_q;
  assign out_data  = out_data_q;

endmodule

// ### src/mlhs_line.sv
// Bit shifter on the modem-supplied clock
`timescale 1ns/100ps
module mlhs_line
  import mlhs_pkg::*;
(
  // Modem clock and reset
  input  wire logic              line_clk,
  input  wire logic              nrst,
  // Transmit word from system domain
  input  wire logic [BYTE_W-1:0] tx_word,
  input  wire logic              tx_req_tgl,
  output logic                   tx_ack_tgl,
  // Receive word to system domain
  input  wire logic              rx_en,
  output logic [BYTE_W-1:0]      rx_word,
  output logic                   rx_tgl,
  // Line pins
  output logic                   txd,
  input  wire logic              rxd
);

  // ****************************************
  // Crossings into this domain
  // ****************************************
  logic req_s1_q, req_s2_q, req_s3_q;
  logic en_s1_q, en_s2_q, en_s3_q, en_f_q;

  always_ff @(posedge line_clk or negedge nrst) begin
    if (!nrst) begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      req_s3_q <= 1'b0;
      en_s1_q  <= 1'b0;
      en_s2_q  <= 1'b0;
      en_s3_q  <= 1'b0;
      en_f_q   <= 1'b0;
    end else begin
      req_s1_q <= tx_req_tgl;
      req_s2_q <= req_s1_q;
      req_s3_q <= req_s2_q;
      en_s1_q  <= rx_en;
      en_s2_q  <= en_s1_q;
      en_s3_q  <= en_s2_q;
      en_f_q   <= (en_s2_q == en_s3_q) ? en_s3_q : en_f_q;
    end
  end

  wire new_word = req_s2_q ^ req_s3_q;

  // ****************************************
  // Transmit shifter, LSB first
  // ****************************************
  logic [BYTE_W-1:0]    tx_sh_q;
  logic [BIT_CNT_W:0]   tx_cnt_q;
  logic                 txd_q;
  logic                 ack_q;

  always_ff @(posedge line_clk or negedge nrst) begin
    if (!nrst) begin
      tx_sh_q  <= '0;
      tx_cnt_q <= '0;
      txd_q    <= 1'b1;
      ack_q    <= 1'b0;
    end else if (new_word) begin
      txd_q    <= tx_word[0];
      tx_sh_q  <= tx_word >> 1;
      tx_cnt_q <= BITS_IN_BYTE - 4'h1;
    end else if (tx_cnt_q != '0) begin
      txd_q    <= tx_sh_q[0];
      tx_sh_q  <= tx_sh_q >> 1;
      tx_cnt_q <= tx_cnt_q - 4'h1;
      ack_q    <= (tx_cnt_q == 4'h1) ? ~ack_q : ack_q;
    end else begin
      // Idle line holds mark
      txd_q    <= 1'b1;
    end
  end

  // ****************************************
  // Receive shifter
  // ****************************************
  logic [BYTE_W-1:0]    rx_sh_q;
  logic [BIT_CNT_W-1:0] rx_cnt_q;
  logic [BYTE_W-1:0]    rx_word_q;
  logic                 rx_tgl_q;

  wire [BYTE_W-1:0] rx_next = {rxd, rx_sh_q[BYTE_W-1:1]};

  always_ff @(posedge line_clk or negedge nrst) begin
    if (!nrst) begin
      rx_sh_q   <= '0;
      rx_cnt_q  <= '0;
      rx_word_q <= '0;
      rx_tgl_q  <= 1'b0;
    end else if (!en_f_q) begin
      rx_cnt_q  <= '0;
    end else begin
      rx_sh_q   <= rx_next;
      rx_cnt_q  <= rx_cnt_q + 3'h1;
      if (rx_cnt_q == LAST_BIT) begin
        // Word stays put for eight line clocks, ample for the far side
        rx_word_q <= rx_next;
        rx_tgl_q  <= ~rx_tgl_q;
      end
    end
  end

  assign tx_ack_tgl = ack_q;
  assign txd        = txd_q;
  assign rx_word    = rx_word_q;
  assign rx_tgl     = rx_tgl_q;

endmodule

// ### src/mlhs_top.sv
// Terminal-side handshake sequencer for a synchronous modem link
//
// Function
// - Terminal raises data terminal ready; calling modem then starts its carrier.
// - Transmitter shifts data out one bit per transmit clock.
// - Receiver shifts data in on the modem receive clock.
// - Terminal drops request to send when done; modem drops carrier and clear to send.
// - Tributary answers only polls with its own address; others keep monitoring.
// - Polled tributary raises request to send, sends only after clear to send.
// - Polled station with no data sends end-of-transmission, drops request, awaits poll.
// - Answering terminal raises data terminal ready so the modem autoanswers.
// - On switched lines with link enable low, terminal drops data terminal ready after transmission completes and, if it autoanswered, after carrier drops.
`timescale 1ns/100ps
module mlhs_top
  import mlhs_pkg::*;
#(
  parameter int unsigned CTS_TIMEOUT_CYCLES = CTS_TIMEOUT_CYC
) (
  // System clock and reset
  input  wire logic              clock,
  input  wire logic              nrst,
  // Modem clock
  input  wire logic              line_clk,
  // Control
  input  wire logic              link_en,
  input  wire logic              mode_trib,
  input  wire logic              mode_switched,
  input  wire logic              auto_answer,
  input  wire logic [BYTE_W-1:0] own_addr,
  // Transmit stream
  input  wire logic              tx_valid,
  input  wire logic [BYTE_W-1:0] tx_data,
  input  wire logic              tx_last,
  output logic                   tx_ready,
  // Receive stream
  output logic                   rx_valid,
  output logic [BYTE_W-1:0]      rx_data,
  input  wire logic              rx_ready,
  // Status
  output logic                   cts_timeout,
  output logic                   rx_overrun,
  output logic                   link_up,
  // Modem interchange lines
  output logic                   dtr,
  output logic                   rts,
  output logic                   txd,
  input  wire logic              rxd,
  input  wire logic              cts,
  input  wire logic              dsr,
  input  wire logic              dcd,
  input  wire logic              ri
);

  localparam int unsigned TO_W = $clog2(CTS_TIMEOUT_CYCLES + 1);
  localparam int unsigned NPIN = 4;

  // ****************************************
  // Pin filters: four flops, change once two agree
  // ****************************************
  wire  [NPIN-1:0] pin_raw = {ri, dcd, dsr, cts};
  logic [NPIN-1:0] pin_f;

  genvar g;
  generate
    for (g = 0; g < NPIN; g++) begin : g_pin
      logic s1_q, s2_q, s3_q, f_q;
      // Reset low matches the idle level of cts, dcd and ri, so no false edge; dsr can idle high
      always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
          s3_q <= 1'b0;
          f_q  <= 1'b0;
        end else begin
          s1_q <= pin_raw[g];
          s2_q <= s1_q;
          s3_q <= s2_q;
          f_q  <= (s2_q == s3_q) ? s3_q : f_q;
        end
      end
      assign pin_f[g] = f_q;
    end
  endgenerate

  wire cts_f = pin_f[0];
  wire dsr_f = pin_f[1];
  wire dcd_f = pin_f[2];
  wire ri_f  = pin_f[3];

  // ****************************************
  // Crossings back from the line domain
  // ****************************************
  logic              tx_ack_tgl, rx_tgl;
  logic [BYTE_W-1:0] rx_word;
  logic ack1_q, ack2_q, ack3_q;
  logic rxt1_q, rxt2_q, rxt3_q;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ack1_q <= 1'b0;
      ack2_q <= 1'b0;
      ack3_q <= 1'b0;
      rxt1_q <= 1'b0;
      rxt2_q <= 1'b0;
      rxt3_q <= 1'b0;
    end else begin
      ack1_q <= tx_ack_tgl;
      ack2_q <= ack1_q;
      ack3_q <= ack2_q;
      rxt1_q <= rx_tgl;
      rxt2_q <= rxt1_q;
      rxt3_q <= rxt2_q;
    end
  end

  // Words stay still while their toggle crosses
  wire word_done = ack2_q ^ ack3_q;
  wire word_rcvd = rxt2_q ^ rxt3_q;

  // ****************************************
  // State and registers
  // ****************************************
  mlhs_state_t       state_q, state_d;
  logic              dtr_q, rts_q, ri_prev_q, answered_q;
  logic              busy_q, last_q, poll_q, first_q, req_tgl_q;
  logic              tx_ready_q, timeout_q, overrun_q, link_up_q;
  logic [BYTE_W-1:0] tx_word_q;
  logic [TO_W-1:0]   to_cnt_q;

  // ****************************************
  // Decode
  // ****************************************
  wire ri_rise     = ri_f && !ri_prev_q;
  wire in_session  = (state_q == ST_WAIT_CTS) || (state_q == ST_SEND) ||
                     (state_q == ST_EOT) || (state_q == ST_DROP);
  wire dtr_want    = link_en || answered_q;
  wire rts_d       = (state_d == ST_WAIT_CTS) || (state_d == ST_SEND) || (state_d == ST_EOT);
  // Held as a turn starts so request to send never stands alone
  wire dtr_d       = (in_session || rts_d) ? 1'b1 : dtr_want;
  wire addr_hit    = word_rcvd && first_q && (rx_word == own_addr);
  wire start_tx    = mode_trib ? poll_q : tx_valid;
  wire tx_take     = (state_q == ST_SEND) && tx_valid && tx_ready_q;
  wire eot_take    = (state_q == ST_WAIT_CTS) && (state_d == ST_EOT);
  wire load_word   = tx_take || eot_take;
  wire busy_d      = load_word ? 1'b1 : (word_done ? 1'b0 : busy_q);
  wire last_d      = (state_q == ST_SEND) && (last_q || (tx_take && tx_last));
  wire tx_ready_d  = (state_d == ST_SEND) && !busy_d && !last_d;
  wire to_hit      = (to_cnt_q == TO_W'(CTS_TIMEOUT_CYCLES));
  wire rx_en       = dtr_q && dcd_f;
  wire buf_ready;
  wire push        = word_rcvd && rx_en;

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_OFF: begin
        // Data set ready marks a modem on the line
        if (dtr_q && dsr_f) state_d = ST_IDLE;
      end
      ST_IDLE: begin
        if (!dtr_q || !dsr_f) state_d = ST_OFF;
        else if (start_tx) state_d = ST_WAIT_CTS;
      end
      ST_WAIT_CTS: begin
        // No data to offer a poll, answer with end of transmission
        if (cts_f) state_d = (mode_trib && !tx_valid) ? ST_EOT : ST_SEND;
      end
      ST_SEND: begin
        if (last_q && !busy_q) state_d = ST_DROP;
      end
      ST_EOT: begin
        if (!busy_q) state_d = ST_DROP;
      end
      ST_DROP: begin
        // Wait for the modem to drop clear to send before a new turn
        if (!cts_f) state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_q    <= ST_OFF;
      dtr_q      <= 1'b0;
      rts_q      <= 1'b0;
      tx_ready_q <= 1'b0;
      busy_q     <= 1'b0;
      last_q     <= 1'b0;
    end else begin
      state_q    <= state_d;
      dtr_q      <= dtr_d;
      rts_q      <= rts_d;
      tx_ready_q <= tx_ready_d;
      busy_q     <= busy_d;
      last_q     <= last_d;
    end
  end

  // ****************************************
  // Transmit word handoff
  // ****************************************
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      tx_word_q <= '0;
      req_tgl_q <= 1'b0;
    end else if (load_word) begin
      // Word held until acknowledged, so the line side reads it stable
      tx_word_q <= eot_take ? EOT_CHAR : tx_data;
      req_tgl_q <= ~req_tgl_q;
    end
  end

  // ****************************************
  // Answer, poll and status tracking
  // ****************************************
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ri_prev_q  <= 1'b0;
      answered_q <= 1'b0;
      poll_q     <= 1'b0;
      first_q    <= 1'b1;
      link_up_q  <= 1'b0;
    end else begin
      ri_prev_q  <= ri_f;
      if (mode_switched && auto_answer && ri_rise) answered_q <= 1'b1;
      else if (!link_en && !in_session && state_q == ST_IDLE && !dcd_f && mode_switched) answered_q <= 1'b0;
      if ((state_q == ST_IDLE) && mode_trib && addr_hit) poll_q <= 1'b1;
      else if (state_q != ST_IDLE) poll_q <= 1'b0;
      // Only the first byte after carrier rise is an address
      if (!dcd_f) first_q <= 1'b1;
      else if (word_rcvd) first_q <= 1'b0;
      link_up_q  <= dtr_q && dsr_f && dcd_f;
    end
  end

  // ****************************************
  // Clear to send watch and receive overrun
  // ****************************************
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      to_cnt_q  <= '0;
      timeout_q <= 1'b0;
      overrun_q <= 1'b0;
    end else begin
      if (state_q != ST_WAIT_CTS) to_cnt_q <= '0;
      else if (!to_hit) to_cnt_q <= to_cnt_q + TO_W'(1);
      if ((state_q == ST_WAIT_CTS) && to_hit) timeout_q <= 1'b1;
      else if (cts_f) timeout_q <= 1'b0;
      // Modem cannot be stalled; a word with no room is counted lost
      if (push && !buf_ready) overrun_q <= 1'b1;
      else if (!link_en) overrun_q <= 1'b0;
    end
  end

  // ****************************************
  // Line side and receive buffer
  // ****************************************
  mlhs_line u_line (
    .line_clk   (line_clk),
    .nrst       (nrst),
    .tx_word    (tx_word_q),
    .tx_req_tgl (req_tgl_q),
    .tx_ack_tgl (tx_ack_tgl),
    .rx_en      (rx_en),
    .rx_word    (rx_word),
    .rx_tgl     (rx_tgl),
    .txd        (txd),
    .rxd        (rxd)
  );

  mlhs_buf #(
    .W (BYTE_W)
  ) u_rx_buf (
    .clock     (clock),
    .nrst      (nrst),
    .in_valid  (push),
    .in_data   (rx_word),
    .in_ready  (buf_ready),
    .out_valid (rx_valid),
    .out_data  (rx_data),
    .out_ready (rx_ready)
  );

  assign dtr         = dtr_q;
  assign rts         = rts_q;
  assign tx_ready    = tx_ready_q;
  assign cts_timeout = timeout_q;
  assign rx_overrun  = overrun_q;
  assign link_up     = link_up_q;

endmodule

// ### verif/mlhs_top_monitor.sv
// Assertion checker for the modem link handshake sequencer
`timescale 1ns/100ps
module mlhs_top_monitor
  import mlhs_pkg::*;
#(
  parameter int unsigned CTS_TIMEOUT_CYCLES = CTS_TIMEOUT_CYC
) (
  // System clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Control and status
  input wire logic link_en,
  input wire logic mode_switched,
  input wire logic tx_ready,
  input wire logic cts_timeout,
  // Interchange lines
  input wire logic dtr,
  input wire logic rts,
  input wire logic txd,
  input wire logic cts,
  input wire logic dsr
);
  // ****************
  // Helper counters
  // ****************
  logic [31:0] wait_q;
  logic [3:0]  dsr_lo_q;
  // Saturates so a long dead line cannot wrap back below the limit
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wait_q   <= 32'h0;
      dsr_lo_q <= 4'h0;
    end else begin
      wait_q   <= (rts && !cts) ? wait_q + 32'h1 : 32'h0;
      dsr_lo_q <= dsr ? 4'h0 : dsr_lo_q + {3'h0, dsr_lo_q != 4'hf};
    end
  end
  // ****************
  // Properties
  // ****************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  property p_dtr_on;
    $rose(link_en) && !mode_switched |=> dtr;
  endproperty
  a_dtr_on: assert property (p_dtr_on) else $error("dtr missed link enable");
  property p_start_dsr;
    $rose(rts) |-> dsr_lo_q < 4'h8;
  endproperty
  a_start_dsr: assert property (p_start_dsr) else $error("turn started with dsr low");
  property p_rts_dtr;
    rts |-> dtr;
  endproperty
  a_rts_dtr: assert property (p_rts_dtr) else $error("rts without dtr");
  property p_ready_cts;
    $rose(tx_ready) |-> $past(cts, 4);
  endproperty
  a_ready_cts: assert property (p_ready_cts) else $error("data taken before cts");
  property p_ready_rts;
    tx_ready |-> rts;
  endproperty
  a_ready_rts: assert property (p_ready_rts) else $error("data taken with rts low");
  property p_rts_drop;
    $fell(rts) |=> !rts [*4];
  endproperty
  a_rts_drop: assert property (p_rts_drop) else $error("rts back before cts drop");
  property p_txd_idle;
    // Last bit may still stand for a line clock after rts falls
    !rts [*8] ##1 !rts [*8] |-> txd;
  endproperty
  a_txd_idle: assert property (p_txd_idle) else $error("txd not idle high");
  property p_timeout;
    wait_q == 32'(CTS_TIMEOUT_CYCLES + 8) |-> cts_timeout;
  endproperty
  a_timeout: assert property (p_timeout) else $error("cts timeout flag missing");
endmodule

bind mlhs_top mlhs_top_monitor #(.CTS_TIMEOUT_CYCLES(CTS_TIMEOUT_CYCLES)) i_mlhs_top_monitor (
  .clock(clock), .nrst(nrst), .link_en(link_en), .mode_switched(mode_switched),
  .tx_ready(tx_ready), .cts_timeout(cts_timeout), .dtr(dtr), .rts(rts), .txd(txd),
  .cts(cts), .dsr(dsr)
);

// ### verif/mlhs_modem.sv
// Behavioural synchronous modem on the far side of the interchange lines
`timescale 1ns/100ps
module mlhs_modem (
  // Clocks
  input  wire logic        clock,
  output logic             line_clk,
  // Bench controls
  input  wire logic        power,
  input  wire logic        sw_line,
  input  wire logic        carrier,
  input  wire logic        ring,
  input  wire logic        rx_on,
  input  wire logic        rx_bit,
  input  wire logic [15:0] cts_wait,
  // Interchange lines
  input  wire logic        dtr,
  input  wire logic        rts,
  input  wire logic        txd,
  output logic             rxd,
  output logic             cts,
  output logic             dsr,
  output logic             dcd,
  output logic             ri,
  // Captured transmit bytes
  output logic [7:0]       got,
  output int               got_n
);
  logic [15:0] dly;
  logic [7:0]  sh;
  int          bit_n;
  // ****************
  // Line clock, free running
  // ****************
  initial begin
    line_clk = 1'b0;
    #3.3;
    forever #62.5 line_clk = ~line_clk;
  end
  // ****************
  // Control lines
  // ****************
  assign dsr = power && (!sw_line || dtr);
  assign dcd = carrier;
  assign ri  = ring && !dtr;
  initial begin
    dly   = 16'h0;
    cts   = 1'b0;
    rxd   = 1'b1;
    sh    = 8'h0;
    got   = 8'h0;
    got_n = 0;
    bit_n = 0;
  end
  always @(posedge clock) begin
    dly <= rts ? dly + {15'h0, dly != 16'hffff} : 16'h0;
    cts <= rts && (dly >= cts_wait);
  end
  // ****************
  // Data lines: rxd never rests on a stale bit
  // ****************
  always @(negedge line_clk) begin
    rxd <= rx_on ? rx_bit : ~rxd;
    if (bit_n != 0 || !txd) begin
      sh    <= {txd, sh[7:1]};
      bit_n <= (bit_n + 1) % 8;
    end
    if (bit_n == 7) begin
      got   <= {txd, sh[7:1]};
      got_n <= got_n + 1;
    end
  end
endmodule

// ### verif/mlhs_top_bench.sv
// Self-checking bench for the modem link handshake sequencer
`timescale 1ns/100ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
`define WAITC(c, n) begin for (int k = 0; k < (n); k++) begin @(negedge clock); if (c) break; end end
module mlhs_top_bench
  import mlhs_pkg::*;
;
  typedef struct { logic [7:0] d; logic [15:0] w; logic [7:0] exp; } mlhs_row_t;
  logic        clock, line_clk, tx_ready, rx_valid, cts_timeout, rx_overrun, link_up;
  logic        dtr, rts, txd, rxd, cts, dsr, dcd, ri;
  logic        nrst = 1'b0, link_en = 1'b0, mode_trib = 1'b0, mode_switched = 1'b0;
  logic        auto_answer = 1'b0, tx_valid = 1'b0, tx_last = 1'b0, rx_ready = 1'b1;
  logic        power = 1'b1, sw_line = 1'b0, carrier = 1'b0, ring = 1'b0, rx_on = 1'b0, rx_bit = 1'b0;
  logic [7:0]  own_addr = 8'hff, tx_data = 8'h0, rx_data, got;
  logic [15:0] cts_wait = 16'h4;
  int          err_count, tests_run, cyc, got_n, n0;
  mlhs_row_t   rows [4] = '{'{8'h5a, 16'h4, 8'h5a}, '{8'ha6, 16'h1e, 8'ha6},
                            '{8'h04, 16'h0, 8'h04}, '{8'hfe, 16'hc, 8'hfe}};

  mlhs_top #(.CTS_TIMEOUT_CYCLES(50)) i_mlhs_top (
    .clock(clock), .nrst(nrst), .line_clk(line_clk), .link_en(link_en), .mode_trib(mode_trib),
    .mode_switched(mode_switched), .auto_answer(auto_answer), .own_addr(own_addr),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready), .cts_timeout(cts_timeout),
    .rx_overrun(rx_overrun), .link_up(link_up), .dtr(dtr), .rts(rts), .txd(txd), .rxd(rxd),
    .cts(cts), .dsr(dsr), .dcd(dcd), .ri(ri)
  );
  mlhs_modem i_mlhs_modem (
    .clock(clock), .line_clk(line_clk), .power(power), .sw_line(sw_line), .carrier(carrier),
    .ring(ring), .rx_on(rx_on), .rx_bit(rx_bit), .cts_wait(cts_wait), .dtr(dtr), .rts(rts),
    .txd(txd), .rxd(rxd), .cts(cts), .dsr(dsr), .dcd(dcd), .ri(ri), .got(got), .got_n(got_n)
  );
  // ****************
  // Clock and hang guard
  // ****************
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    if (err_count == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ****************
  // One byte offered and held until taken
  // ****************
  task automatic send(input logic [7:0] d, input logic last, input logic to);
    @(posedge clock);
    tx_valid <= 1'b1;
    tx_data  <= d;
    tx_last  <= last;
    if (to) begin
      `WAITC(cts_timeout, 200)
      `CHK({cts_timeout, tx_ready}, 2'b10)
    end
    `WAITC(tx_ready, 2000)
    `CHK(tx_ready, 1'b1)
    @(posedge clock);
    tx_valid <= 1'b0;
  endtask
  // ****************
  // Main sequence
  // ****************
  initial begin
    repeat (20) @(posedge clock);
    nrst    <= 1'b1;
    link_en <= 1'b1;
    `WAITC(dtr, 4)
    `CHK(dtr, 1'b1)
    foreach (rows[i]) begin
      @(posedge clock);
      cts_wait <= rows[i].w;
      n0 = got_n;
      send(rows[i].d, 1'b1, 1'b0);
      `WAITC(!rts && got_n != n0, 1500)
      `CHK({rts, got}, {1'b0, rows[i].exp})
    end
    // Two bytes in one turn, second offered while the first shifts
    n0 = got_n;
    send(8'h5a, 1'b0, 1'b0);
    send(8'h3c, 1'b1, 1'b0);
    `WAITC(!rts && got_n == n0 + 2, 1500)
    `CHK(got, 8'h3c)
    `CHK(got_n, n0 + 2)
    // Slow modem: flag raised while waiting, gone once cts comes
    @(posedge clock);
    cts_wait <= 16'hc8;
    send(8'h12, 1'b1, 1'b1);
    @(negedge clock);
    `CHK(cts_timeout, 1'b0)
    `WAITC(!rts, 1500)
    // Tributary: foreign address, receiver stalled until overrun
    @(posedge clock);
    cts_wait  <= 16'ha;
    mode_trib <= 1'b1;
    rx_on     <= 1'b1;
    rx_ready  <= 1'b0;
    repeat (60) @(posedge clock);
    carrier <= 1'b1;
    `WAITC(rx_overrun, 800)
    `CHK({rx_overrun, rx_valid, rx_data}, 10'h300)
    `CHK({rts, link_up}, 2'b01)
    @(posedge clock);
    carrier  <= 1'b0;
    rx_ready <= 1'b1;
    link_en  <= 1'b0;
    repeat (30) @(posedge clock);
    `CHK(rx_overrun, 1'b0)
    // Tributary: own address, nothing to send
    link_en  <= 1'b1;
    rx_bit   <= 1'b1;
    rx_ready <= 1'b0;
    repeat (60) @(posedge clock);
    carrier <= 1'b1;
    n0 = got_n;
    `WAITC(rts, 600)
    `CHK(rts, 1'b1)
    `WAITC(rx_valid, 20)
    `CHK(rx_data, 8'hff)
    `WAITC(!rts && got_n != n0, 1500)
    `CHK(got, EOT_CHAR)
    repeat (300) @(posedge clock);
    `CHK(rts, 1'b0)
    // Switched line with autoanswer
    carrier       <= 1'b0;
    rx_on         <= 1'b0;
    rx_ready      <= 1'b1;
    mode_trib     <= 1'b0;
    link_en       <= 1'b0;
    mode_switched <= 1'b1;
    auto_answer   <= 1'b1;
    sw_line       <= 1'b1;
    repeat (20) @(posedge clock);
    `CHK(dtr, 1'b0)
    ring <= 1'b1;
    `WAITC(dtr, 20)
    `CHK(dtr, 1'b1)
    @(posedge clock);
    ring <= 1'b0;
    send(8'h5a, 1'b1, 1'b0);
    `WAITC(!dtr, 1500)
    `CHK(dtr, 1'b0)
    // Reset in mid-run
    @(posedge clock);
    nrst <= 1'b0;
    repeat (30) @(posedge clock);
    `CHK({dtr, rts, txd, tx_ready, rx_valid, cts_timeout, rx_overrun, link_up}, 8'h20)
    nrst <= 1'b1;
    repeat (2) @(negedge clock);
    `CHK({dtr, rts, txd, link_up}, 4'h2)
    repeat (10) @(posedge clock);
    end_of_test();
  end
endmodule
